/* rtl/global_option_config_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module global_option_config_regs (
  input  wire logic       CLK_I,            // Core clock
  input  wire logic       RST_I,            // Hardware reset
  input  wire logic       CFG_WR_I,         // Config data write strobe
  input  wire logic       CFG_RD_I,         // Config data read strobe
  input  wire logic [7:0] CFG_IDX_I,        // Selected index
  input  wire logic [7:0] CFG_WDATA_I,      // Write data
  output logic      [7:0] CFG_RDATA_O,      // Read data
  input  wire logic       STRAP_PORT_SEL_I, // Serial A request strap pin
  input  wire logic       INPUT_RATE_CHOICE_I, // 1: fast input clock
  input  wire logic       FLOPPY_OFF_I,     // Floppy interface disabled
  input  wire logic       FDC_OUT_BIT3_I,   // Floppy output reg bit 3
  input  wire logic       PORT_CTL_BIT4_I,  // Parallel control reg bit 4
  input  wire logic [5:0] HS_CTL_BIT3_I,    // Serial A..F handshake bit 3
  input  wire logic       OVERTEMP_ALERT_I, // Overtemp alert, active low
  input  wire logic       SYS_MGMT_INT_I,   // Mgmt interrupt, active low
  input  wire logic       FLOPPY_WRITE_STREAM_I, // Floppy write data
  input  wire logic       SERIAL_F_TX_I,    // Serial F transmit data
  input  wire logic [3:0] GROUP6_OUT_I,     // Group 6 bits 0..3 out
  input  wire logic [3:0] GROUP6_OE_I,      // Group 6 bits 0..3 enables
  output logic      [7:0] KEY_PORT_O,       // Active key port address
  output logic      [7:0] KEY_BYTE_O,       // Unlock key byte
  output logic            CFG_ACCESS_OK_O,  // Accesses allowed
  output logic            SERIAL_B_FLOAT_O, // Float serial B pins
  output logic            SERIAL_A_FLOAT_O, // Float serial A pins
  output logic            PARALLEL_FLOAT_O, // Float parallel pins
  output logic            FLOPPY_FLOAT_O,   // Float floppy pins
  output logic            FDC_IRQ_GATE_O,   // Floppy IRQ gate
  output logic            PAR_IRQ_GATE_O,   // Parallel IRQ gate
  output logic      [5:0] SER_IRQ_GATE_O,   // Serial A..F IRQ gates
  output logic            PAR_NORMAL_MODE_O, // Normal parallel mode
  output logic      [3:0] GROUP_PUSH_PULL_O, // Groups 6,5,4,3 type
  output logic            PIN95_O,          // Pin 95 drive
  output logic            PIN95_OE_O,       // Pin 95 enable
  output logic            LED_O,            // Power LED drive
  output logic            LED_OE_O,         // Power LED enable
  output logic      [3:0] SHARED_OUT_O,     // Pins 11,14,16,18 drive
  output logic      [3:0] SHARED_OE_O       // Pins 11,14,16,18 enables
);
  // All register state in one struct
  typedef struct packed {
    logic [7:0] tri_r;  // Interface float register
    logic [7:0] opt26;  // Port select, lock, legacy bits
    logic [7:0] opt28;  // Serial legacy bits, parallel mode
    logic [7:0] otype;  // Output types, pin 95, LED
    logic [7:0] rdata;  // Read data
    logic       s1;     // Strap synchroniser stage one
    logic       s2;     // Strap synchroniser stage two
    logic       strap_done; // Strap captured since reset
    logic [1:0] fill;   // Edges since release, strap wait
    logic [1:0] led;    // Registered LED pin drive / enable
  } st_s;
  st_s r_q, r_d;
  led_if lk ();
  logic  ok;      // Lock open
  logic  hit_wr;  // Accepted write
  logic  [7:0] rd_mux; // Read selection

  localparam int B_LED_HI = glob_cfg_pkg::B_LED_HI;
  localparam int B_LED_LO = glob_cfg_pkg::B_LED_LO;

  led_blink u_blink (
    .CLK_I (CLK_I),
    .RST_I (RST_I),
    .lk    (lk)
  );
  assign lk.mode   = r_q.otype[B_LED_HI:B_LED_LO];
  assign lk.rate48 = INPUT_RATE_CHOICE_I;

  // Lock gates both directions; the lock bit itself stays writable so
  // software can reopen access (otherwise the bank locks forever)
  assign ok     = !r_q.opt26[glob_cfg_pkg::B_LOCK];
  assign hit_wr = CFG_WR_I && (ok || CFG_IDX_I == glob_cfg_pkg::OFS_OPT26);

  // Read selection
  always_comb begin
    case (CFG_IDX_I)
      glob_cfg_pkg::OFS_TRI:   rd_mux = r_q.tri_r;
      glob_cfg_pkg::OFS_OPT26: rd_mux = r_q.opt26;
      glob_cfg_pkg::OFS_OPT28: rd_mux = r_q.opt28;
      glob_cfg_pkg::OFS_OTYPE: rd_mux = r_q.otype;
      default:                 rd_mux = 8'h00; // Reserved index reads 0
    endcase
  end

  // Next-state logic
  always_comb begin
    r_d    = r_q;
    r_d.s1 = STRAP_PORT_SEL_I;
    r_d.s2 = r_q.s1;
    // Capture strap once the synchroniser has filled after release;
    // taking it earlier would load the reset value of stage two
    if (!r_q.strap_done) begin
      if (r_q.fill == glob_cfg_pkg::STRAP_LOAD_CNT) begin
        r_d.opt26[glob_cfg_pkg::B_PORT_SEL] = r_q.s2;
        r_d.strap_done = 1'b1;
      end else begin
        r_d.fill = r_q.fill + 2'h1;
      end
    end else if (hit_wr) begin
      case (CFG_IDX_I)
        glob_cfg_pkg::OFS_TRI:
          r_d.tri_r = CFG_WDATA_I & glob_cfg_pkg::MASK_TRI;
        glob_cfg_pkg::OFS_OPT26: begin
          if (ok) begin
            r_d.opt26 = CFG_WDATA_I & glob_cfg_pkg::MASK_OPT26;
          end else begin
            r_d.opt26[glob_cfg_pkg::B_LOCK] =
              CFG_WDATA_I[glob_cfg_pkg::B_LOCK];
          end
        end
        glob_cfg_pkg::OFS_OPT28:
          r_d.opt28 = CFG_WDATA_I & glob_cfg_pkg::MASK_OPT28;
        glob_cfg_pkg::OFS_OTYPE:
          r_d.otype = CFG_WDATA_I & glob_cfg_pkg::MASK_OTYPE;
        default: ;
      endcase
    end
    // Locked reads return zero
    if (CFG_RD_I) begin
      r_d.rdata = ok ? rd_mux : 8'h00;
    end
    // LED pin: {drive, enable}
    case (r_q.otype[B_LED_HI:B_LED_LO])
      glob_cfg_pkg::LED_FLOAT: r_d.led = 2'b00;
      glob_cfg_pkg::LED_LOW:   r_d.led = 2'b01;
      default:                 r_d.led = {lk.blink, 1'b1};
    endcase
  end

  // State register
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      r_q       <= '0;
      r_q.tri_r <= glob_cfg_pkg::RST_TRI;
      r_q.opt26 <= glob_cfg_pkg::RST_OPT26;
      r_q.opt28 <= glob_cfg_pkg::RST_OPT28;
      r_q.otype <= glob_cfg_pkg::RST_OTYPE;
    end else begin
      r_q <= r_d;
    end
  end

  assign CFG_RDATA_O     = r_q.rdata;
  assign CFG_ACCESS_OK_O = ok;
  assign KEY_BYTE_O      = glob_cfg_pkg::KEY_BYTE;
  assign KEY_PORT_O = r_q.opt26[glob_cfg_pkg::B_PORT_SEL]
                    ? glob_cfg_pkg::KEY_PORT_HI
                    : glob_cfg_pkg::KEY_PORT_LO;

  // Float controls
  assign SERIAL_B_FLOAT_O = r_q.tri_r[glob_cfg_pkg::B_SERB_FLOAT];
  assign SERIAL_A_FLOAT_O = r_q.tri_r[glob_cfg_pkg::B_SERA_FLOAT];
  assign PARALLEL_FLOAT_O = r_q.tri_r[glob_cfg_pkg::B_PAR_FLOAT];
  assign FLOPPY_FLOAT_O   = r_q.tri_r[glob_cfg_pkg::B_FDC_FLOAT];

  // Legacy IRQ gates: disable bit forces the gate open
  assign FDC_IRQ_GATE_O = FDC_OUT_BIT3_I
                        | r_q.opt26[glob_cfg_pkg::B_FDC_LIRQ];
  assign PAR_IRQ_GATE_O = PORT_CTL_BIT4_I
                        | r_q.opt26[glob_cfg_pkg::B_PAR_LIRQ];
  assign SER_IRQ_GATE_O = HS_CTL_BIT3_I | {
    r_q.opt28[glob_cfg_pkg::B_SERF_LIRQ],
    r_q.opt28[glob_cfg_pkg::B_SERE_LIRQ],
    r_q.opt28[glob_cfg_pkg::B_SERD_LIRQ],
    r_q.opt28[glob_cfg_pkg::B_SERC_LIRQ],
    r_q.opt26[glob_cfg_pkg::B_SERB_LIRQ],
    r_q.opt26[glob_cfg_pkg::B_SERA_LIRQ]};

  assign PAR_NORMAL_MODE_O = !r_q.opt28[glob_cfg_pkg::B_PMODE_TOP];
  assign GROUP_PUSH_PULL_O = {r_q.otype[glob_cfg_pkg::B_G6_PP],
                              r_q.otype[glob_cfg_pkg::B_G5_PP],
                              r_q.otype[glob_cfg_pkg::B_G4_PP],
                              r_q.otype[glob_cfg_pkg::B_G3_PP]};

  // Pin 95: open-drain alert, drives low only while asserted
  assign PIN95_O    = 1'b0;
  assign PIN95_OE_O = r_q.otype[glob_cfg_pkg::B_PIN95_SEL]
                    ? !SYS_MGMT_INT_I : !OVERTEMP_ALERT_I;

  assign LED_O    = r_q.led[1];
  assign LED_OE_O = r_q.led[0];

  // Shared pins: index 3 pin 11 data, 2..0 pins 14,16,18 group 6 bits
  // Floppy inputs on 14/16/18 need no drive, so only pin 11 drives then
  assign SHARED_OUT_O = FLOPPY_OFF_I
    ? {SERIAL_F_TX_I, GROUP6_OUT_I[3], GROUP6_OUT_I[1], GROUP6_OUT_I[0]}
    : {FLOPPY_WRITE_STREAM_I, 3'h0};
  assign SHARED_OE_O = r_q.tri_r[glob_cfg_pkg::B_FDC_FLOAT] ? 4'h0
    : FLOPPY_OFF_I
    ? {1'b1, GROUP6_OE_I[3], GROUP6_OE_I[1], GROUP6_OE_I[0]}
    : 4'h8;

  chk_lock_write: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    r_q.strap_done && CFG_WR_I && !ok && CFG_IDX_I == 8'h25
    |=> $stable(r_q.tri_r))
    else $error("write landed while locked");
  chk_lock_read: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    CFG_RD_I && !ok |=> CFG_RDATA_O == 8'h00)
    else $error("read data leaked while locked");
  chk_float_write: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    r_q.strap_done && CFG_WR_I && ok && CFG_IDX_I == 8'h25
    |=> SERIAL_B_FLOAT_O == $past(CFG_WDATA_I[5])
        && FLOPPY_FLOAT_O == $past(CFG_WDATA_I[0]))
    else $error("float bits not taken from write");
  // Strap pin level three edges back is the one that stage two held
  chk_strap_load: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    !r_q.strap_done && r_q.fill == 2'h2
    |=> KEY_PORT_O == ($past(STRAP_PORT_SEL_I, 3) ? 8'h4e : 8'h2e))
    else $error("port select not loaded from strap");
  chk_key_port: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    KEY_PORT_O == 8'h2e || KEY_PORT_O == 8'h4e)
    else $error("key port out of range");
  chk_fdc_gate: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    r_q.opt26[3] |-> FDC_IRQ_GATE_O)
    else $error("floppy gate not forced");
  chk_par_gate: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    !r_q.opt26[2] |-> PAR_IRQ_GATE_O == PORT_CTL_BIT4_I)
    else $error("parallel gate wrong");
  chk_serf_gate: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    !r_q.opt28[7] |-> SER_IRQ_GATE_O[5] == HS_CTL_BIT3_I[5])
    else $error("serial F gate wrong");
  chk_led_low: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    r_q.otype[2:1] == 2'h1 ##1 r_q.otype[2:1] == 2'h1
    |-> LED_OE_O && !LED_O)
    else $error("LED not driven low");
  chk_pin95_sel: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    r_q.otype[6] |-> PIN95_OE_O == !SYS_MGMT_INT_I)
    else $error("pin 95 source wrong");
  cov_locked: cover property (@(posedge CLK_I) disable iff (RST_I)
    $fell(ok));
  cov_blink: cover property (@(posedge CLK_I) disable iff (RST_I)
    LED_OE_O && $rose(LED_O));
  cov_remap: cover property (@(posedge CLK_I) disable iff (RST_I)
    FLOPPY_OFF_I && SHARED_OE_O[3]);
endmodule // global_option_config_regs
`default_nettype wire

/* rtl/glob_cfg_pkg.sv */
package glob_cfg_pkg;
  // Configuration index offsets
  localparam logic [7:0] OFS_TRI    = 8'h25;
  localparam logic [7:0] OFS_OPT26  = 8'h26;
  localparam logic [7:0] OFS_RSV27  = 8'h27;
  localparam logic [7:0] OFS_OPT28  = 8'h28;
  localparam logic [7:0] OFS_OTYPE  = 8'h29;
  // Writable masks (reserved bits read zero)
  localparam logic [7:0] MASK_TRI   = 8'h39;
  localparam logic [7:0] MASK_OPT26 = 8'h6f;
  localparam logic [7:0] MASK_OPT28 = 8'hf7;
  localparam logic [7:0] MASK_OTYPE = 8'hfe;
  // Reset values
  localparam logic [7:0] RST_TRI    = 8'h00;
  localparam logic [7:0] RST_OPT26  = 8'h00;
  localparam logic [7:0] RST_OPT28  = 8'h00;
  localparam logic [7:0] RST_OTYPE  = 8'h00;
  // Field positions
  localparam int B_SERB_FLOAT = 5;
  localparam int B_SERA_FLOAT = 4;
  localparam int B_PAR_FLOAT  = 3;
  localparam int B_FDC_FLOAT  = 0;
  localparam int B_PORT_SEL   = 6;
  localparam int B_LOCK       = 5;
  localparam int B_FDC_LIRQ   = 3;
  localparam int B_PAR_LIRQ   = 2;
  localparam int B_SERA_LIRQ  = 1;
  localparam int B_SERB_LIRQ  = 0;
  localparam int B_SERF_LIRQ  = 7;
  localparam int B_SERE_LIRQ  = 6;
  localparam int B_SERD_LIRQ  = 5;
  localparam int B_SERC_LIRQ  = 4;
  localparam int B_PMODE_TOP  = 2;
  localparam int B_G6_PP      = 7;
  localparam int B_PIN95_SEL  = 6;
  localparam int B_G5_PP      = 5;
  localparam int B_G4_PP      = 4;
  localparam int B_G3_PP      = 3;
  localparam int B_LED_HI     = 2;
  localparam int B_LED_LO     = 1;
  // Key address choices and key byte
  localparam logic [7:0] KEY_PORT_LO = 8'h2e;
  localparam logic [7:0] KEY_PORT_HI = 8'h4e;
  localparam logic [7:0] KEY_BYTE    = 8'h87;
  // LED modes
  localparam logic [1:0] LED_FLOAT = 2'h0;
  localparam logic [1:0] LED_LOW   = 2'h1;
  localparam logic [1:0] LED_1HZ   = 2'h2;
  localparam logic [1:0] LED_QHZ   = 2'h3;
  // Timing: clock rate figures and LED half periods
  localparam longint CLK_HZ       = 250000000;
  localparam longint RATE_LO_MHZ  = 24;
  localparam longint RATE_HI_MHZ  = 48;
  localparam longint HALF_1HZ_MS  = 500;
  localparam longint HALF_QHZ_MS  = 2000;
  // Cycles per half period of the 1 Hz blink at the fast input rate
  localparam longint HALF_1HZ_CYC = CLK_HZ * HALF_1HZ_MS / 1000;
  localparam int     QHZ_DIV      = int'(HALF_QHZ_MS / HALF_1HZ_MS);
  // Edges after reset release before the strap level is taken
  localparam logic [1:0] STRAP_LOAD_CNT = 2'h2;
endpackage

/* rtl/led_if.sv */
`timescale 1ns/1ns
`default_nettype none
// Carries the LED mode down and the blink level back
interface led_if;
  logic [1:0] mode;   // Selected power LED mode
  logic       rate48; // Input clock is the fast choice
  logic       blink;  // Square wave level
  modport ctl (output mode, output rate48, input blink);
  modport gen (input mode, input rate48, output blink);
endinterface
`default_nettype wire

/* rtl/led_blink.sv */
`timescale 1ns/1ns
`default_nettype none
module led_blink #(
  parameter longint HALF_CYC = glob_cfg_pkg::HALF_1HZ_CYC
) (
  input  wire logic CLK_I,
  input  wire logic RST_I,
  led_if.gen        lk
);
  typedef struct packed {
    logic [31:0] cnt;  // Cycles into the current 1 Hz half period
    logic [1:0]  sub;  // Half-period count for the slow wave
    logic        fast; // 1 Hz level
    logic        slow; // Quarter-hertz level
  } blk_s;
  blk_s r_q, r_d;
  logic [31:0] lim; // Terminal count for the chosen input rate
  logic        run; // A blink mode is selected

  // Scale by input rate choice: slower input means fewer ticks
  always_comb begin
    if (lk.rate48) begin
      lim = 32'(HALF_CYC - 1);
    end else begin
      lim = 32'(HALF_CYC * glob_cfg_pkg::RATE_LO_MHZ
                / glob_cfg_pkg::RATE_HI_MHZ - 1);
    end
  end
  assign run = lk.mode[1];

  // Divider free-runs only in blink modes; held at zero otherwise
  always_comb begin
    r_d = r_q;
    if (!run) begin
      r_d = '0;
    end else if (r_q.cnt >= lim) begin
      r_d.cnt  = '0;
      r_d.fast = ~r_q.fast;
      r_d.sub  = r_q.sub + 2'h1;
      if (r_q.sub == 2'(glob_cfg_pkg::QHZ_DIV - 1)) begin
        r_d.slow = ~r_q.slow;
        r_d.sub  = '0;
      end
    end else begin
      r_d.cnt = r_q.cnt + 32'h1;
    end
  end

  // State register
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // 50% duty: each wave toggles every half period
  assign lk.blink = (lk.mode == glob_cfg_pkg::LED_1HZ) ? r_q.fast
                                                       : r_q.slow;

  chk_blink_idle: assert property (
    @(posedge CLK_I) disable iff (RST_I)
    !run |=> r_q.cnt == 32'h0)
    else $error("blink counter not held idle");
  cov_fast_toggle: cover property (@(posedge CLK_I) disable iff (RST_I)
    $changed(r_q.fast));
endmodule // led_blink
`default_nettype wire

/* dv/cfg_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Host side of the index/data configuration port
module cfg_host_model (
  input  wire logic       clk_i,   // Core clock
  output var  logic       wr_o,    // Data write strobe
  output var  logic       rd_o,    // Data read strobe
  output var  logic [7:0] idx_o,   // Selected index
  output var  logic [7:0] wdata_o, // Write data
  input  wire logic [7:0] rdata_i  // Read data
);
  // Idle at time zero, strobes low
  initial begin
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    idx_o   = 8'h00;
    wdata_o = 8'h00;
  end

  // One-cycle write; index and data inverted when idle so stale
  // values cannot pass for a fresh cycle
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    @(posedge clk_i);
    idx_o   <= idx;
    wdata_o <= dat;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    idx_o   <= ~idx;
    wdata_o <= ~dat;
  endtask

  // One-cycle read; data is taken an edge after the strobe edge
  task automatic rd(input logic [7:0] idx, output logic [7:0] dat);
    @(posedge clk_i);
    idx_o <= idx;
    rd_o  <= 1'b1;
    @(posedge clk_i);
    rd_o  <= 1'b0;
    idx_o <= ~idx;
    @(posedge clk_i);
    dat = rdata_i;
  endtask
endmodule // cfg_host_model
`default_nettype wire

/* dv/global_option_config_regs_test.sv */
`timescale 1ns/1ns
`default_nettype none
module global_option_config_regs_test;
  logic       clk = 1'b0;      // Core clock
  logic       rst = 1'b1;      // Hardware reset
  logic       strap = 1'b1;    // Port select strap level
  logic       rate = 1'b1;     // Fast input clock
  logic       fd_off = 1'b0;   // Floppy disabled
  logic       fd_b3 = 1'b0;    // Floppy output reg bit 3
  logic       pr_b4 = 1'b0;    // Parallel control bit 4
  logic [5:0] hs_b3 = 6'h00;   // Handshake bit 3, A..F
  logic       ovt_n = 1'b1;    // Overtemp alert
  logic       smi_n = 1'b1;    // Mgmt interrupt
  logic       fws = 1'b0;      // Floppy write stream
  logic       sftx = 1'b0;     // Serial F transmit
  logic [3:0] g6o = 4'h0;      // Group 6 outputs
  logic [3:0] g6e = 4'h0;      // Group 6 enables
  logic       wr, rd;          // Host strobes
  logic [7:0] idx, wd, rdat;   // Host index, data, read data
  logic [7:0] kport, kbyte;    // Key port and byte
  logic       ok, fb, fa, fp, ff, fg, pg, pn, p95, p95e, led, lede;
  logic [5:0] sg;              // Serial gates
  logic [3:0] gpp, sho, she;   // Push-pull, shared pins
  int         error_cnt = 0;   // Mismatches
  int         num_checks = 0;  // Comparisons

  // Free-running 250 MHz clock
  always #2 clk = ~clk;

  cfg_host_model host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .idx_o(idx),
    .wdata_o(wd), .rdata_i(rdat));

  global_option_config_regs dut (.CLK_I(clk), .RST_I(rst), .CFG_WR_I(wr),
    .CFG_RD_I(rd), .CFG_IDX_I(idx), .CFG_WDATA_I(wd), .CFG_RDATA_O(rdat),
    .STRAP_PORT_SEL_I(strap), .INPUT_RATE_CHOICE_I(rate),
    .FLOPPY_OFF_I(fd_off), .FDC_OUT_BIT3_I(fd_b3), .PORT_CTL_BIT4_I(pr_b4),
    .HS_CTL_BIT3_I(hs_b3), .OVERTEMP_ALERT_I(ovt_n), .SYS_MGMT_INT_I(smi_n),
    .FLOPPY_WRITE_STREAM_I(fws), .SERIAL_F_TX_I(sftx), .GROUP6_OUT_I(g6o),
    .GROUP6_OE_I(g6e), .KEY_PORT_O(kport), .KEY_BYTE_O(kbyte),
    .CFG_ACCESS_OK_O(ok), .SERIAL_B_FLOAT_O(fb), .SERIAL_A_FLOAT_O(fa),
    .PARALLEL_FLOAT_O(fp), .FLOPPY_FLOAT_O(ff), .FDC_IRQ_GATE_O(fg),
    .PAR_IRQ_GATE_O(pg), .SER_IRQ_GATE_O(sg), .PAR_NORMAL_MODE_O(pn),
    .GROUP_PUSH_PULL_O(gpp), .PIN95_O(p95), .PIN95_OE_O(p95e), .LED_O(led),
    .LED_OE_O(lede), .SHARED_OUT_O(sho), .SHARED_OE_O(she));

  // Verdict and end of run, shared with the watchdog
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Case equality so an unknown never matches
  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Register read with expected byte
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.rd(a, v);
    chk("rdata", e, v);
  endtask

  // Let the last edge's updates land
  task automatic tick();
    @(posedge clk);
  endtask

  // Drive config writes, then let outputs settle
  task automatic wt(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    tick();
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rdchk(glob_cfg_pkg::OFS_TRI, glob_cfg_pkg::RST_TRI);
    rdchk(glob_cfg_pkg::OFS_OPT26, 8'h40);
    rdchk(glob_cfg_pkg::OFS_OPT28, glob_cfg_pkg::RST_OPT28);
    rdchk(glob_cfg_pkg::OFS_OTYPE, glob_cfg_pkg::RST_OTYPE);
    chk("key_port", glob_cfg_pkg::KEY_PORT_HI, kport);
    chk("key_byte", glob_cfg_pkg::KEY_BYTE, kbyte);
    // Float bits, one pattern then all
    wt(8'h25, 8'h21);
    chk("float", 8'h09, {4'h0, fb, fa, fp, ff});
    wt(8'h25, 8'hff);
    chk("float", 8'h0f, {4'h0, fb, fa, fp, ff});
    rdchk(8'h25, 8'h39);
    // Legacy disables force gates regardless of the unit bits
    wt(8'h26, 8'h4f);
    wt(8'h28, 8'hf0);
    chk("gates", 8'hff, {fg, pg, sg});
    rdchk(8'h26, 8'h4f);
    rdchk(8'h28, 8'hf0);
    // Legacy enabled: unit bits pass, C and E still disabled
    fd_b3 <= 1'b1;
    hs_b3 <= 6'h2a;
    wt(8'h26, 8'h40);
    wt(8'h28, 8'h50);
    chk("gates", 8'hbe, {fg, pg, sg});
    // Parallel mode top bit
    wt(8'h28, 8'h04);
    chk("par_norm", 8'h00, pn);
    wt(8'h28, 8'h03);
    chk("par_norm", 8'h01, pn);
    // Group output types
    wt(8'h29, 8'hb8);
    chk("push_pull", 8'h0f, gpp);
    wt(8'h29, 8'h20);
    chk("push_pull", 8'h04, gpp);
    // Pin 95 source: alert first, then management interrupt
    ovt_n <= 1'b0;
    tick();
    tick();
    chk("pin95", 8'h02, {p95e, p95});
    wt(8'h29, 8'h60);
    chk("pin95", 8'h00, {p95e, p95});
    smi_n <= 1'b0;
    tick();
    tick();
    chk("pin95", 8'h02, {p95e, p95});
    // LED float and driven low; blink halves are too long to reach
    wt(8'h29, 8'h00);
    tick();
    chk("led_oe", 8'h00, lede);
    wt(8'h29, 8'h02);
    tick();
    chk("led", 8'h02, {lede, led});
    rate <= 1'b0;
    // Blink modes drive the pin, first half period low
    wt(8'h29, 8'h04);
    tick();
    chk("led_blink", 8'h02, {lede, led});
    wt(8'h29, 8'h06);
    tick();
    chk("led_blink", 8'h02, {lede, led});
    // Shared pins; bit 2 unused so pin order cannot hide a slip
    wt(8'h25, 8'h00);
    fd_off <= 1'b1;
    sftx   <= 1'b1;
    g6o    <= 4'hb;
    g6e    <= 4'hb;
    tick();
    tick();
    chk("shared", 8'hff, {sho, she});
    fd_off <= 1'b0;
    fws    <= 1'b1;
    tick();
    tick();
    chk("shared", 8'h88, {sho[3], 3'h0, she});
    wt(8'h25, 8'h01);
    chk("shared_oe", 8'h00, she);
    // Lock blocks writes and reads until reopened
    wt(8'h25, 8'h10);
    wt(8'h26, 8'h20);
    chk("access_ok", 8'h00, ok);
    wt(8'h25, 8'hff);
    rdchk(8'h25, 8'h00);
    wt(8'h26, 8'h00);
    chk("access_ok", 8'h01, ok);
    rdchk(8'h25, 8'h10);
    chk("key_port", glob_cfg_pkg::KEY_PORT_LO, kport);
    // Reserved and unmapped slots
    wt(8'h27, 8'hff);
    rdchk(8'h27, 8'h00);
    rdchk(8'h2a, 8'h00);
    // Second reset with strap low
    strap <= 1'b0;
    rst   <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rdchk(8'h26, 8'h00);
    rdchk(8'h25, 8'h00);
    chk("key_port", glob_cfg_pkg::KEY_PORT_LO, kport);
    stop_test();
  end

  // Watchdog: the sequence needs well under 1000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
endmodule // global_option_config_regs_test
`default_nettype wire
